/* common/irq_pkg.sv */
// Shared constants and types of the interrupt controller and status word
package irq_pkg;
	// Bus
	localparam int         AXI_ADDR_W  = 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register byte offsets
	localparam logic [7:0] OFS_STATUS    = 8'h00;
	localparam logic [7:0] OFS_CONTROL   = 8'h04;
	localparam logic [7:0] OFS_ENABLE    = 8'h08;
	localparam logic [7:0] OFS_PENDING   = 8'h0C;
	localparam logic [7:0] OFS_ACTIVE    = 8'h10;
	localparam logic [7:0] OFS_PRIO_BASE = 8'h20;
	// Field positions
	localparam int CTRL_IPL3_BIT  = 3;
	localparam int CTRL_NEST_BIT  = 15;
	localparam int PEND_TRAP_LSB  = 24;
	localparam int ACT_VEC_LSB    = 0;
	localparam int ACT_LEVEL_LSB  = 8;
	localparam int ACT_BUSY_BIT   = 12;
	localparam int PRIO_FIELD_W   = 4;
	localparam int PRIO_PER_WORD  = 8;
	// Reset values
	localparam logic [15:0] STATUS_RESET  = 16'h0000;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET  = 32'h0000_0000;
	localparam logic [31:0] PRIO_RESET    = 32'h0000_0000;
	// Vector table and priority
	localparam logic [23:0] VT_BASE          = 24'h000004;
	localparam logic [23:0] VT_STRIDE        = 24'h000002;
	localparam int          NUM_TRAP_DEF     = 7;
	localparam int          NUM_SRC_DEF      = 16;
	localparam int          FIRST_IRQ_VECTOR = 8;
	localparam logic [3:0]  TRAP_LEVEL       = 4'hF;
	localparam logic [2:0]  IPL_NEST_BLOCK   = 3'h7;
	// Fixed latencies in core clock cycles, and depth of the nesting stack
	localparam int ENTRY_CYCLES_DEF  = 10;
	localparam int RETURN_CYCLES_DEF = 10;
	localparam int STACK_DEPTH_DEF   = 8;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_FETCH  = 6'h02,
		ST_LOAD   = 6'h04,
		ST_OFFER  = 6'h08,
		ST_ENTRY  = 6'h10,
		ST_RETURN = 6'h20
	} ctrl_state_e;

	typedef struct packed {
		logic       acc_a_overflow_flag;
		logic       acc_b_overflow_flag;
		logic       acc_a_saturation_sticky;
		logic       acc_b_saturation_sticky;
		logic       combined_overflow_flag;
		logic       combined_saturation_sticky;
		logic       loop_active;
		logic       half_carry;
		logic [2:0] cpu_priority_level;
		logic       repeat_active;
		logic       negative;
		logic       overflow;
		logic       zero;
		logic       carry;
	} status_word_s;

	typedef struct packed {
		logic [7:0]  vector;
		logic [23:0] handler;
	} cpu_request_s;
endpackage : irq_pkg

/* rtl/irq_arbiter.sv */
// Combinational selection of the winning trap or interrupt source
`timescale 1ns/10ps
`default_nettype none
module irq_arbiter #(
	parameter int NUM_SRC  = irq_pkg::NUM_SRC_DEF,
	parameter int NUM_TRAP = irq_pkg::NUM_TRAP_DEF
) (
	input  wire logic [NUM_SRC-1:0]        pending,
	input  wire logic [NUM_SRC-1:0]        enable,
	input  wire logic [NUM_SRC-1:0][2:0]   prio,
	input  wire logic [NUM_TRAP-1:0]       trap,
	input  wire logic [3:0]                cpu_level,
	output logic                           found,
	output logic                           is_trap,
	output logic [7:0]                     vector,
	output logic [3:0]                     level
);
	logic [2:0] best;

	always_comb begin
		found = 1'b0;
		is_trap = 1'b0;
		vector = 8'h00;
		level = 4'h0;
		best = 3'h0;
		// Downward scan so the lower vector wins a tie
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i] && enable[i] && !cpu_level[3]
				&& prio[i] > cpu_level[2:0]
				&& prio[i] >= best) begin
				found = 1'b1;
				best = prio[i];
				vector = 8'(irq_pkg::FIRST_IRQ_VECTOR + i);
				level = {1'b0, prio[i]};
			end
		end
		// Traps are not masked and outrank every interrupt
		for (int t = NUM_TRAP - 1; t >= 0; t--) begin
			if (trap[t]) begin
				found = 1'b1;
				is_trap = 1'b1;
				vector = 8'(t);
				level = irq_pkg::TRAP_LEVEL;
			end
		end
	end
endmodule : irq_arbiter
`default_nettype wire

/* rtl/status_word_reg.sv */
// CPU status word with priority level and accumulator flags
`timescale 1ns/10ps
`default_nettype none
module status_word_reg (
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic          wr_en,
	input  wire logic [15:0]   wr_data,
	input  wire logic [1:0]    wr_strb,
	input  wire logic          nesting_disable,
	input  wire logic          hw_load,
	input  wire logic [2:0]    hw_level,
	input  wire logic          acc_a_overflow,
	input  wire logic          acc_b_overflow,
	input  wire logic          acc_a_saturate,
	input  wire logic          acc_b_saturate,
	output irq_pkg::status_word_s status_word
);
	irq_pkg::status_word_s s;
	irq_pkg::status_word_s n;
	irq_pkg::status_word_s w;

	always_comb begin
		w = irq_pkg::status_word_s'(wr_data);
		n = s;
		n.acc_a_overflow_flag = acc_a_overflow;
		n.acc_b_overflow_flag = acc_b_overflow;
		// Written flag survives only if the combined flag is written as one
		if (wr_en && wr_strb[1]) begin
			n.acc_a_saturation_sticky = w.acc_a_saturation_sticky
				& w.combined_saturation_sticky;
			n.acc_b_saturation_sticky = w.acc_b_saturation_sticky
				& w.combined_saturation_sticky;
			n.half_carry = w.half_carry;
		end
		// A saturation event wins over a clearing write
		if (acc_a_saturate)
			n.acc_a_saturation_sticky = 1'b1;
		if (acc_b_saturate)
			n.acc_b_saturation_sticky = 1'b1;
		if (wr_en && wr_strb[0]) begin
			if (!nesting_disable)
				n.cpu_priority_level = w.cpu_priority_level;
			n.negative = w.negative;
			n.overflow = w.overflow;
			n.zero = w.zero;
			n.carry = w.carry;
		end
		if (hw_load)
			n.cpu_priority_level = hw_level;
		n.combined_overflow_flag = 1'b0;
		n.combined_saturation_sticky = 1'b0;
		n.loop_active = 1'b0;
		n.repeat_active = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			s <= irq_pkg::status_word_s'(irq_pkg::STATUS_RESET);
		else
			s <= n;
	end

	always_comb begin
		status_word = s;
		status_word.combined_overflow_flag = s.acc_a_overflow_flag
			| s.acc_b_overflow_flag;
		status_word.combined_saturation_sticky = s.acc_a_saturation_sticky
			| s.acc_b_saturation_sticky;
	end
endmodule : status_word_reg
`default_nettype wire

/* rtl/irq_priority_and_status.sv */
// Interrupt controller front end with status word and AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module irq_priority_and_status #(
	parameter int NUM_SRC       = irq_pkg::NUM_SRC_DEF,
	parameter int NUM_TRAP      = irq_pkg::NUM_TRAP_DEF,
	parameter int ENTRY_CYCLES  = irq_pkg::ENTRY_CYCLES_DEF,
	parameter int RETURN_CYCLES = irq_pkg::RETURN_CYCLES_DEF,
	parameter int STACK_DEPTH   = irq_pkg::STACK_DEPTH_DEF,
	parameter int ADDR_W        = irq_pkg::AXI_ADDR_W
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [NUM_SRC-1:0]    irq_lines,
	input  wire logic [NUM_TRAP-1:0]   trap_req,
	input  wire logic                  acc_a_overflow,
	input  wire logic                  acc_b_overflow,
	input  wire logic                  acc_a_saturate,
	input  wire logic                  acc_b_saturate,
	output logic                       pm_rd_en,
	output logic [23:0]                pm_rd_addr,
	input  wire logic [23:0]           pm_rd_data,
	output logic                       cpu_irq_req,
	output irq_pkg::cpu_request_s      cpu_request,
	input  wire logic                  cpu_irq_ack,
	input  wire logic                  cpu_return_req,
	output logic                       cpu_entry_done,
	output logic                       cpu_return_done,
	output logic [3:0]                 cpu_level,
	output irq_pkg::status_word_s      cpu_status_word
);
	localparam int PRIO_WORDS = (NUM_SRC + irq_pkg::PRIO_PER_WORD - 1)
		/ irq_pkg::PRIO_PER_WORD;
	localparam int SP_W = $clog2(STACK_DEPTH);

	typedef struct packed {
		irq_pkg::ctrl_state_e          st;
		logic [7:0]                    cnt;
		logic                          aw_held;
		logic [ADDR_W-1:0]             aw_addr;
		logic                          w_held;
		logic [31:0]                   w_data;
		logic [3:0]                    w_strb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
		logic                          ipl3;
		logic                          nest_dis;
		logic [31:0]                   enable;
		logic [PRIO_WORDS-1:0][31:0]   prio;
		logic [7:0]                    vec;
		logic [23:0]                   handler;
		logic                          is_trap;
		logic [3:0]                    new_level;
		logic [STACK_DEPTH-1:0][3:0]   stack;
		logic [SP_W:0]                 sp;
		logic                          entry_done;
		logic                          return_done;
		logic                          pm_rd_en;
		logic [23:0]                   pm_addr;
	} state_s;

	state_s                       s;
	state_s                       n;
	logic [NUM_SRC-1:0][2:0]      src_prio;
	logic                         win_found;
	logic                         win_trap;
	logic [7:0]                   win_vector;
	logic [3:0]                   win_level;
	logic                         sw_wr;
	logic                         ipl_load;
	logic [2:0]                   ipl_val;
	logic                         wr_go;
	irq_pkg::status_word_s        sw;

	// Merge byte lanes of a write into the old register value
	function automatic logic [31:0] apply_strb(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[b*8 +: 8] = new_val[b*8 +: 8];
		end
		return r;
	endfunction : apply_strb

	// Byte address of one priority word
	function automatic logic [ADDR_W-1:0] prio_addr(input int k);
		return ADDR_W'(irq_pkg::OFS_PRIO_BASE + 4 * k);
	endfunction : prio_addr

	// Whether an address hits a mapped register
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = (a == ADDR_W'(irq_pkg::OFS_STATUS))
			|| (a == ADDR_W'(irq_pkg::OFS_CONTROL))
			|| (a == ADDR_W'(irq_pkg::OFS_ENABLE))
			|| (a == ADDR_W'(irq_pkg::OFS_PENDING))
			|| (a == ADDR_W'(irq_pkg::OFS_ACTIVE));
		for (int k = 0; k < PRIO_WORDS; k++) begin
			if (a == prio_addr(k))
				hit = 1'b1;
		end
		return hit;
	endfunction : is_mapped

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : gen_prio
			assign src_prio[g] = s.prio[g / irq_pkg::PRIO_PER_WORD]
				[(g % irq_pkg::PRIO_PER_WORD) * irq_pkg::PRIO_FIELD_W +: 3];
		end
	endgenerate

	irq_arbiter #(
		.NUM_SRC   (NUM_SRC),
		.NUM_TRAP  (NUM_TRAP)
	) u_arbiter (
		.pending   (irq_lines),
		.enable    (s.enable[NUM_SRC-1:0]),
		.prio      (src_prio),
		.trap      (trap_req),
		.cpu_level (cpu_level),
		.found     (win_found),
		.is_trap   (win_trap),
		.vector    (win_vector),
		.level     (win_level)
	);

	status_word_reg u_status (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.wr_en           (sw_wr),
		.wr_data         (s.w_data[15:0]),
		.wr_strb         (s.w_strb[1:0]),
		.nesting_disable (s.nest_dis),
		.hw_load         (ipl_load),
		.hw_level        (ipl_val),
		.acc_a_overflow  (acc_a_overflow),
		.acc_b_overflow  (acc_b_overflow),
		.acc_a_saturate  (acc_a_saturate),
		.acc_b_saturate  (acc_b_saturate),
		.status_word     (sw)
	);

	assign wr_go = s.aw_held && s.w_held;
	assign sw_wr = wr_go && (s.aw_addr == ADDR_W'(irq_pkg::OFS_STATUS));

	always_comb begin
		logic [31:0]   rd;
		logic [31:0]   tmp;
		logic [SP_W:0] top;
		rd = 32'h0000_0000;
		tmp = 32'h0000_0000;
		top = s.sp - 1'b1;
		n = s;
		n.entry_done = 1'b0;
		n.return_done = 1'b0;
		n.pm_rd_en = 1'b0;
		ipl_load = 1'b0;
		ipl_val = sw.cpu_priority_level;
		// Write channels taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_held = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_held = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = is_mapped(s.aw_addr) ? irq_pkg::RESP_OKAY
				: irq_pkg::RESP_SLVERR;
			if (s.aw_addr == ADDR_W'(irq_pkg::OFS_CONTROL)) begin
				tmp = 32'h0000_0000;
				tmp[irq_pkg::CTRL_IPL3_BIT] = s.ipl3;
				tmp[irq_pkg::CTRL_NEST_BIT] = s.nest_dis;
				tmp = apply_strb(tmp, s.w_data, s.w_strb);
				n.ipl3 = tmp[irq_pkg::CTRL_IPL3_BIT];
				n.nest_dis = tmp[irq_pkg::CTRL_NEST_BIT];
			end
			if (s.aw_addr == ADDR_W'(irq_pkg::OFS_ENABLE))
				n.enable = apply_strb(s.enable, s.w_data, s.w_strb);
			for (int k = 0; k < PRIO_WORDS; k++) begin
				if (s.aw_addr == prio_addr(k))
					n.prio[k] = apply_strb(s.prio[k], s.w_data,
						s.w_strb);
			end
		end
		if (s.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		// Read channel
		if (s_axi_arvalid && s_axi_arready) begin
			if (s_axi_araddr == ADDR_W'(irq_pkg::OFS_STATUS))
				rd[15:0] = sw;
			if (s_axi_araddr == ADDR_W'(irq_pkg::OFS_CONTROL)) begin
				rd[irq_pkg::CTRL_IPL3_BIT] = s.ipl3;
				rd[irq_pkg::CTRL_NEST_BIT] = s.nest_dis;
			end
			if (s_axi_araddr == ADDR_W'(irq_pkg::OFS_ENABLE))
				rd = s.enable;
			if (s_axi_araddr == ADDR_W'(irq_pkg::OFS_PENDING)) begin
				rd[NUM_SRC-1:0] = irq_lines;
				rd[irq_pkg::PEND_TRAP_LSB +: NUM_TRAP] = trap_req;
			end
			if (s_axi_araddr == ADDR_W'(irq_pkg::OFS_ACTIVE)) begin
				rd[irq_pkg::ACT_VEC_LSB +: 8] = s.vec;
				rd[irq_pkg::ACT_LEVEL_LSB +: 4] = cpu_level;
				rd[irq_pkg::ACT_BUSY_BIT] = (s.st != irq_pkg::ST_IDLE);
			end
			for (int k = 0; k < PRIO_WORDS; k++) begin
				if (s_axi_araddr == prio_addr(k))
					rd = s.prio[k];
			end
			n.rvalid = 1'b1;
			n.rdata = rd;
			n.rresp = is_mapped(s_axi_araddr) ? irq_pkg::RESP_OKAY
				: irq_pkg::RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		// Service sequence
		case (s.st)
			irq_pkg::ST_IDLE: begin
				if (cpu_return_req) begin
					n.st = irq_pkg::ST_RETURN;
					n.cnt = 8'(RETURN_CYCLES - 1);
				end else if (win_found) begin
					n.vec = win_vector;
					n.is_trap = win_trap;
					n.new_level = win_level;
					n.pm_addr = 24'(irq_pkg::VT_BASE
						+ win_vector * irq_pkg::VT_STRIDE);
					n.pm_rd_en = 1'b1;
					n.st = irq_pkg::ST_FETCH;
				end
			end
			irq_pkg::ST_FETCH: begin
				n.st = irq_pkg::ST_LOAD;
			end
			irq_pkg::ST_LOAD: begin
				n.handler = pm_rd_data;
				n.st = irq_pkg::ST_OFFER;
			end
			irq_pkg::ST_OFFER: begin
				if (!win_found) begin
					n.st = irq_pkg::ST_IDLE;
				end else if (cpu_irq_ack) begin
					if (s.sp != (SP_W + 1)'(STACK_DEPTH)) begin
						n.stack[s.sp[SP_W-1:0]] = {s.ipl3,
							sw.cpu_priority_level};
						n.sp = s.sp + 1'b1;
					end
					if (s.is_trap) begin
						n.ipl3 = 1'b1;
					end else begin
						ipl_load = 1'b1;
						ipl_val = s.nest_dis ? irq_pkg::IPL_NEST_BLOCK
							: s.new_level[2:0];
					end
					n.st = irq_pkg::ST_ENTRY;
					n.cnt = 8'(ENTRY_CYCLES - 1);
				end
			end
			irq_pkg::ST_ENTRY: begin
				if (s.cnt == 8'h00) begin
					n.entry_done = 1'b1;
					n.st = irq_pkg::ST_IDLE;
				end else begin
					n.cnt = s.cnt - 8'h01;
				end
			end
			irq_pkg::ST_RETURN: begin
				if (s.cnt == 8'h00) begin
					if (s.sp != '0) begin
						n.ipl3 = s.stack[top[SP_W-1:0]][3];
						ipl_load = 1'b1;
						ipl_val = s.stack[top[SP_W-1:0]][2:0];
						n.sp = top;
					end
					n.return_done = 1'b1;
					n.st = irq_pkg::ST_IDLE;
				end else begin
					n.cnt = s.cnt - 8'h01;
				end
			end
			default: begin
				n.st = irq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= irq_pkg::ST_IDLE;
			s.ipl3 <= irq_pkg::CONTROL_RESET[irq_pkg::CTRL_IPL3_BIT];
			s.nest_dis <= irq_pkg::CONTROL_RESET[irq_pkg::CTRL_NEST_BIT];
			s.enable <= irq_pkg::ENABLE_RESET;
			s.prio <= {PRIO_WORDS{irq_pkg::PRIO_RESET}};
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = !s.aw_held && !s.bvalid;
	assign s_axi_wready = !s.w_held && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign pm_rd_en = s.pm_rd_en;
	assign pm_rd_addr = s.pm_addr;
	assign cpu_irq_req = (s.st == irq_pkg::ST_OFFER);
	assign cpu_request.vector = s.vec;
	assign cpu_request.handler = s.handler;
	assign cpu_entry_done = s.entry_done;
	assign cpu_return_done = s.return_done;
	assign cpu_level = {s.ipl3, sw.cpu_priority_level};
	assign cpu_status_word = sw;
endmodule : irq_priority_and_status
`default_nettype wire

/* verification/irq_checker.sv */
// Concurrent checks on the interrupt controller top-level ports
`timescale 1ns/10ps
`default_nettype none
module irq_checker #(
	parameter int NUM_SRC       = 16,
	parameter int NUM_TRAP      = 7,
	parameter int ENTRY_CYCLES  = 10,
	parameter int RETURN_CYCLES = 10
) (
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	input wire logic                  s_axi_bvalid,
	input wire logic                  acc_a_saturate,
	input wire logic                  acc_b_overflow,
	input wire logic [NUM_SRC-1:0]    irq_lines,
	input wire logic [NUM_TRAP-1:0]   trap_req,
	input wire logic                  pm_rd_en,
	input wire logic [23:0]           pm_rd_addr,
	input wire logic [23:0]           pm_rd_data,
	input wire logic                  cpu_irq_req,
	input wire irq_pkg::cpu_request_s cpu_request,
	input wire logic                  cpu_irq_ack,
	input wire logic                  cpu_return_req,
	input wire logic                  cpu_entry_done,
	input wire logic                  cpu_return_done,
	input wire logic [3:0]            cpu_level,
	input wire irq_pkg::status_word_s cpu_status_word
);
	// Done pulses land one edge after the counter reaches zero
	localparam int ENTRY_LAT  = ENTRY_CYCLES + 1;
	localparam int RETURN_LAT = RETURN_CYCLES + 1;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_fetch;
		pm_rd_en;
	endsequence
	sequence s_take;
		cpu_irq_req && cpu_irq_ack;
	endsequence
	a_handler_load: assert property (s_fetch |=> ##1
		cpu_irq_req && cpu_request.handler == $past(pm_rd_data))
		else $error("handler not taken from table");
	a_vector_slot: assert property (s_fetch |=> ##1
		({15'h0, cpu_request.vector, 1'h0} + 24'h4 == $past(pm_rd_addr, 2)))
		else $error("table address does not match vector");
	a_fetch_cause: assert property (s_fetch |-> $past(|trap_req ||
		(!cpu_level[3] && |irq_lines)))
		else $error("fetch without unmasked request");
	a_offer_stable: assert property (cpu_irq_req && $past(cpu_irq_req)
		|-> $stable(cpu_request))
		else $error("request changed while offered");
	a_entry_fixed: assert property (s_take |-> ##ENTRY_LAT
		cpu_entry_done)
		else $error("entry latency wrong");
	a_return_fixed: assert property (cpu_return_req &&
		$past(cpu_entry_done) |-> ##RETURN_LAT cpu_return_done)
		else $error("return latency wrong");
	a_trap_level: assert property (s_take ##0
		(cpu_request.vector < 8'h08) |=> cpu_level[3])
		else $error("trap did not raise fourth level bit");
	a_ovf_b_tracks: assert property ($past(rst_n) |->
		cpu_status_word.acc_b_overflow_flag == $past(acc_b_overflow))
		else $error("overflow B flag wrong");
	a_sat_set: assert property (acc_a_saturate |=>
		cpu_status_word.acc_a_saturation_sticky)
		else $error("saturation A not set");
	a_sat_sticky: assert property ($past(rst_n) &&
		!$rose(s_axi_bvalid) &&
		$past(cpu_status_word.acc_a_saturation_sticky)
		|-> cpu_status_word.acc_a_saturation_sticky)
		else $error("saturation A lost without write");
	a_combined_or: assert property (
		cpu_status_word.combined_overflow_flag ==
		(cpu_status_word.acc_a_overflow_flag
		| cpu_status_word.acc_b_overflow_flag) &&
		cpu_status_word.combined_saturation_sticky ==
		(cpu_status_word.acc_a_saturation_sticky
		| cpu_status_word.acc_b_saturation_sticky))
		else $error("combined flags wrong");
endmodule : irq_checker
bind irq_priority_and_status irq_checker #(
	.NUM_SRC(NUM_SRC),
	.NUM_TRAP(NUM_TRAP),
	.ENTRY_CYCLES(ENTRY_CYCLES),
	.RETURN_CYCLES(RETURN_CYCLES)
) chk (
	.core_clk        (core_clk),
	.rst_n           (rst_n),
	.s_axi_bvalid    (s_axi_bvalid),
	.acc_a_saturate  (acc_a_saturate),
	.acc_b_overflow  (acc_b_overflow),
	.irq_lines       (irq_lines),
	.trap_req        (trap_req),
	.pm_rd_en        (pm_rd_en),
	.pm_rd_addr      (pm_rd_addr),
	.pm_rd_data      (pm_rd_data),
	.cpu_irq_req     (cpu_irq_req),
	.cpu_request     (cpu_request),
	.cpu_irq_ack     (cpu_irq_ack),
	.cpu_return_req  (cpu_return_req),
	.cpu_entry_done  (cpu_entry_done),
	.cpu_return_done (cpu_return_done),
	.cpu_level       (cpu_level),
	.cpu_status_word (cpu_status_word)
);
`default_nettype wire

/* verification/cpu_core_model.sv */
// Core and program memory model facing the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        pm_rd_en,
	input wire logic [23:0] pm_rd_addr,
	output logic [23:0]     pm_rd_data,
	input wire logic        cpu_irq_req,
	input wire logic        cpu_entry_done,
	input wire logic [3:0]  ack_wait,
	output logic            cpu_irq_ack,
	output logic            cpu_return_req
);
	logic [3:0] cnt;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pm_rd_data <= 24'h5A5A5A;
			cnt <= 4'h0;
			cpu_irq_ack <= 1'h0;
			cpu_return_req <= 1'h0;
		end else begin
			// Word valid one cycle after the read, scrambled otherwise
			pm_rd_data <= pm_rd_en ? (24'hA00000 | pm_rd_addr) : ~pm_rd_data;
			cpu_return_req <= cpu_entry_done;
			if (cpu_irq_req && !cpu_irq_ack && cnt == ack_wait) begin
				cpu_irq_ack <= 1'h1;
				cnt <= 4'h0;
			end else begin
				cpu_irq_ack <= 1'h0;
				cnt <= cpu_irq_req && !cpu_irq_ack ? cnt + 4'h1 : 4'h0;
			end
		end
	end
endmodule : cpu_core_model
`default_nettype wire

/* verification/irq_priority_and_status_tb.sv */
// Self-checking bench for the interrupt controller and status word
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %0h want %0h", $time, g, e); end end
module irq_priority_and_status_tb;
	typedef struct {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [31:0] e;
		logic [1:0]  r;
	} row_s;
	localparam logic [1:0] OK = irq_pkg::RESP_OKAY;
	localparam logic [1:0] ER = irq_pkg::RESP_SLVERR;
	int failures = 0;
	int cmp_count = 0;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = '0, ack_wait = '0, cpu_level;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, pm_rd_en, cpu_irq_req, cpu_irq_ack, cpu_return_req;
	logic cpu_entry_done, cpu_return_done;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [23:0] pm_rd_addr, pm_rd_data;
	logic [15:0] irq_lines = '0;
	logic [6:0] trap_req = '0;
	logic acc_a_overflow = 0, acc_b_overflow = 0;
	logic acc_a_saturate = 0, acc_b_saturate = 0;
	irq_pkg::cpu_request_s cpu_request;
	irq_pkg::status_word_s cpu_status_word;
	row_s rows [18] = '{
		'{0, 8'h00, 0, 4'hF, 32'h0, OK}, '{0, 8'h04, 0, 4'hF, 32'h0, OK},
		'{1, 8'h00, 32'h35EF, 4'hF, 0, OK}, '{0, 8'h00, 0, 4'hF, 32'h35EF, OK},
		'{1, 8'h00, 32'h0, 4'h2, 0, OK}, '{0, 8'h00, 0, 4'hF, 32'hEF, OK},
		'{1, 8'h04, 32'h8000, 4'hF, 0, OK}, '{1, 8'h00, 32'h3400, 4'hF, 0, OK},
		'{0, 8'h00, 0, 4'hF, 32'h34E0, OK}, '{1, 8'h04, 32'h0, 4'hF, 0, OK},
		'{1, 8'h00, 32'h0, 4'hF, 0, OK}, '{0, 8'h00, 0, 4'hF, 32'h0, OK},
		'{1, 8'h08, 32'hFFFF, 4'hF, 0, OK}, '{0, 8'h08, 0, 4'hF, 32'hFFFF, OK},
		'{1, 8'h20, 32'h533, 4'hF, 0, OK}, '{0, 8'h20, 0, 4'hF, 32'h533, OK},
		'{1, 8'h40, 32'h1, 4'hF, 0, ER}, '{0, 8'h40, 0, 4'hF, 32'h0, ER}};

	irq_priority_and_status uut (.*);
	cpu_core_model partner (.*);

	always #2 core_clk = ~core_clk;

	task automatic wrap_up;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		logic done;
		@(posedge core_clk);
		done = 0;
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= s;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			s_axi_bready <= 1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1;
			s_axi_rready <= 1;
		end
		while (!done) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) begin
				rsp = s_axi_bresp;
				done = 1;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				rsp = s_axi_rresp;
				rdat = s_axi_rdata;
				done = 1;
			end
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
	endtask : bus

	task automatic svc(input logic [15:0] l, input logic [6:0] t,
		input logic [7:0] v, input logic [3:0] lv, input logic [3:0] dl);
		logic [23:0] h;
		h = irq_pkg::VT_BASE + 24'(v) * irq_pkg::VT_STRIDE;
		@(posedge core_clk);
		irq_lines <= l;
		trap_req <= t;
		ack_wait <= dl;
		while (!cpu_irq_req) @(posedge core_clk);
		`CHK(cpu_request.vector, v)
		`CHK(cpu_request.handler, 24'hA00000 | h)
		// Sources drop at the ack edge so a held trap is not taken again
		while (!(cpu_irq_req && cpu_irq_ack)) @(posedge core_clk);
		irq_lines <= '0;
		trap_req <= '0;
		while (!cpu_entry_done) @(posedge core_clk);
		`CHK(cpu_level, lv)
		while (!cpu_return_done) @(posedge core_clk);
		@(posedge core_clk);
		`CHK(cpu_level, 4'h0)
	endtask : svc

	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1;
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].d, rows[i].s);
			`CHK(rsp, rows[i].r)
			if (!rows[i].wr) `CHK(rdat, rows[i].e)
		end
		svc(16'h0003, 7'h00, 8'h08, 4'h3, 4'h0);
		svc(16'h0005, 7'h00, 8'h0A, 4'h5, 4'h3);
		svc(16'h0001, 7'h06, 8'h01, 4'h8, 4'h1);
		svc(16'h0000, 7'h01, 8'h00, 4'h8, 4'h0);
		bus(1, 8'h04, 32'h8000, 4'hF);
		svc(16'h0004, 7'h00, 8'h0A, 4'h7, 4'h0);
		bus(0, 8'h10, 0, 4'hF);
		`CHK(rdat, 32'hA)
		bus(1, 8'h04, 32'h8, 4'hF);
		irq_lines <= 16'h0004;
		bus(0, 8'h0C, 0, 4'hF);
		`CHK(rdat, 32'h4)
		repeat (8) @(posedge core_clk);
		`CHK(cpu_irq_req, 1'h0)
		irq_lines <= '0;
		bus(1, 8'h04, 32'h0, 4'hF);
		acc_a_saturate <= 1;
		acc_b_overflow <= 1;
		@(posedge core_clk);
		acc_a_saturate <= 0;
		repeat (3) @(posedge core_clk);
		`CHK(cpu_status_word[15:10], 6'b011011)
		acc_b_overflow <= 0;
		repeat (3) @(posedge core_clk);
		`CHK(cpu_status_word[15:10], 6'b001001)
		bus(1, 8'h00, 32'h0, 4'hF);
		`CHK(cpu_status_word[13:10], 4'h0)
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		wrap_up();
	end
endmodule : irq_priority_and_status_tb
`default_nettype wire
